// ### rtl/clock_source_pkg.sv
// constants, register map and types for the clock source control block
package clock_source_pkg;

	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int CLK_FREQ_KHZ = CLK_FREQ_HZ / 1_000;
	localparam int CLK_FREQ_MHZ = CLK_FREQ_HZ / 1_000_000;

	// low-speed internal oscillator, nominal 32.768 kHz
	localparam int LOW_SPEED_FREQ_HZ = 32_768;
	localparam int LOW_SPEED_DIV = CLK_FREQ_HZ / LOW_SPEED_FREQ_HZ;
	localparam int LOW_DIV_W = 16;

	// main internal oscillator, 8 MHz, period trimmed around nominal
	localparam int MAIN_OSC_FREQ_KHZ = 8_000;
	localparam int MAIN_DIV_W = 6;
	localparam logic [MAIN_DIV_W-1:0] MAIN_DIV_NOM = MAIN_DIV_W'(CLK_FREQ_KHZ / MAIN_OSC_FREQ_KHZ);
	localparam logic [MAIN_DIV_W-1:0] MAIN_TRIM_SPAN = 6'h04;
	localparam logic [MAIN_DIV_W-1:0] MAIN_DIV_MIN = MAIN_DIV_NOM - MAIN_TRIM_SPAN;
	localparam logic [MAIN_DIV_W-1:0] MAIN_DIV_MAX = MAIN_DIV_NOM + MAIN_TRIM_SPAN;
	localparam int SOF_FRAME_US = 1_000;
	localparam int FRAME_W = 16;
	localparam logic [FRAME_W-1:0] MAIN_TICKS_PER_FRAME = FRAME_W'(MAIN_OSC_FREQ_KHZ * SOF_FRAME_US / 1_000);

	// crystal oscillator stabilisation interval
	localparam int CRYSTAL_STAB_TIME_US = 1_000;
	localparam int CRYSTAL_STAB_CYCLES = CRYSTAL_STAB_TIME_US * CLK_FREQ_MHZ;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CRYSTAL_OSC_CONFIG_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CRYSTAL_OSC_TRIM_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CRYSTAL_OSC_STATUS_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] LOW_SPEED_OSC_CONFIG_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] WATCHDOG_CONTROL_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] BACKUP_DOMAIN_CONTROL_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] MAIN_OSC_CONTROL_OFS = 8'h18;

	// crystal_osc_config_reg
	localparam int CRYSTAL_ENABLE_BIT = 0;
	localparam int AUTO_GAIN_BIT = 1;
	// crystal_osc_trim_reg
	localparam int AMP_TRIM_LSB = 0;
	localparam int AMP_TRIM_W = 4;
	localparam int DET_TRIM_LSB = 4;
	localparam int DET_TRIM_W = 3;
	localparam int GAIN_TRIM_LSB = 8;
	localparam int GAIN_TRIM_W = 3;
	localparam int RES_TRIM_LSB = 12;
	localparam int RES_TRIM_W = 2;
	localparam int FILT_TRIM_LSB = 16;
	localparam int FILT_TRIM_W = 3;
	// crystal_osc_status_reg
	localparam int CRYSTAL_READY_BIT = 0;
	// low_speed_osc_config_reg
	localparam int LOW_ENABLE_BIT = 0;
	localparam int KEEP_ALIVE_BIT = 1;
	// watchdog_control_reg
	localparam int WD_ENABLE_BIT = 0;
	localparam int WD_LOCK_BIT = 1;
	// backup_domain_control_reg
	localparam int WATCH_ENABLE_BIT = 0;
	localparam int WATCH_BYPASS_BIT = 1;
	localparam int LF_SEL_WATCH_BIT = 2;
	// main osc control
	localparam int FRAME_LOCK_BIT = 0;
	localparam int ROOT_SEL_LSB = 4;
	localparam int MAIN_PERIOD_LSB = 8;

	// reset values
	localparam logic LOW_ENABLE_RST = 1'b1;
	localparam logic WD_LOCK_RST = 1'b0;

	typedef enum logic [1:0] {
		ROOT_MAIN,
		ROOT_EXTERNAL,
		ROOT_CRYSTAL
	} root_sel_e;

	typedef enum logic [1:0] {
		PWR_LP,
		PWR_ULP,
		PWR_DEEPSLEEP,
		PWR_HIBERNATE
	} power_mode_e;

endpackage : clock_source_pkg

// ### rtl/ready_timer_if.sv
// enable and ready pair between the control logic and the stabilisation timer
`timescale 1ns/1ns
interface ready_timer_if;
	logic enable;
	logic ready;

	modport owner (output enable, input ready);
	modport timer (input enable, output ready);
endinterface : ready_timer_if

// ### rtl/ready_timer.sv
// stabilisation timer behind the crystal oscillator ready status
`timescale 1ns/1ns
module ready_timer
	import clock_source_pkg::*;
#(
	parameter int STAB_CYCLES = CRYSTAL_STAB_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	ready_timer_if.timer port
);
	localparam int CNT_W = $clog2(STAB_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STAB_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic ready;
	} timer_s;

	timer_s s_r;
	timer_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (!port.enable)
		begin
			// dropping the enable restarts the whole interval
			s_nxt.count = '0;
			s_nxt.ready = 1'b0;
		end
		else if (!s_r.ready)
		begin
			if (s_r.count == CNT_LAST)
				s_nxt.ready = 1'b1;
			else
				s_nxt.count = s_r.count + CNT_ONE;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign port.ready = s_r.ready;
endmodule : ready_timer

// ### rtl/clock_source_control.sv
// clock source control: oscillator enables, trims, ready status and tick selection
//
// Summary of operation
// - while the watchdog lock is set, writes disabling the low-speed oscillator are ignored
// - turning the watchdog on forces the low-speed oscillator enable on; a power event in the same cycle overrides it
// - the watchdog counter tick always comes from the low-speed oscillator
// - one enable bit starts and stops the low-speed oscillator; leave it on
// - keep-alive bit keeps the low-speed oscillator running through hibernate, POR, brownout
// - low-speed oscillator is a free-running 32.768 kHz tick in every power mode
// - low-frequency clock picks low-speed or watch crystal; feeds backup domain and multi-counter watchdogs
// - amplitude trim sets drive level only with auto gain; auto gain below 2 V
// - write trims before enabling the crystal oscillator, then poll its ready status
// - external clock pin, up to 100 MHz, is offered as a clock path source
// - main oscillator gives 8 MHz, trimmed from USB frame markers only when locked
// - main oscillator runs only in the low-power and ultra-low-power modes
// - watch crystal enable starts and stops the 32.768 kHz watch crystal oscillator
// - watch crystal bypass passes an external clock from the pin instead
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module clock_source_control
	import clock_source_pkg::*;
#(
	parameter int CRYSTAL_STAB_CYCLES_P = CRYSTAL_STAB_CYCLES,
	parameter int LOW_SPEED_DIV_P = LOW_SPEED_DIV
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdata,
	input wire power_mode_e powerMode,
	input wire logic powerEvent,
	input wire logic usbSof,
	input wire logic crystalOscClk,
	input wire logic externalClockPin,
	input wire logic watchCrystalOscClk,
	input wire logic watchCrystalPinClk,
	output logic crystalOscEnable,
	output logic crystalAutoGain,
	output logic [AMP_TRIM_W-1:0] crystalDriveLevel,
	output logic [DET_TRIM_W-1:0] amplitudeDetectTrim,
	output logic [GAIN_TRIM_W-1:0] gainTrim,
	output logic [RES_TRIM_W-1:0] filterResistorTrim,
	output logic [FILT_TRIM_W-1:0] filterTrim,
	output logic crystalOscReady,
	output logic lowSpeedOscRun,
	output logic watchCrystalOscRun,
	output logic watchdogTick,
	output logic backupDomainTick,
	output logic multiWatchdogTick,
	output logic mainOscTick,
	output logic clockPathTick
);
	localparam logic [LOW_DIV_W-1:0] LOW_DIV_LAST = LOW_DIV_W'(LOW_SPEED_DIV_P - 1);
	localparam logic [LOW_DIV_W-1:0] LOW_DIV_ONE = LOW_DIV_W'(1);
	localparam logic [MAIN_DIV_W-1:0] MAIN_ONE = MAIN_DIV_W'(1);
	localparam logic [FRAME_W-1:0] FRAME_ONE = FRAME_W'(1);
	localparam logic [FRAME_W-1:0] FRAME_SAT = '1;

	typedef struct packed {
		logic crystalEnable;
		logic autoGain;
		logic [AMP_TRIM_W-1:0] ampTrim;
		logic [DET_TRIM_W-1:0] detTrim;
		logic [GAIN_TRIM_W-1:0] gainTrim;
		logic [RES_TRIM_W-1:0] resTrim;
		logic [FILT_TRIM_W-1:0] filtTrim;
		logic [AMP_TRIM_W-1:0] driveLevel;
		logic lowEnable;
		logic keepAlive;
		logic wdEnable;
		logic wdLock;
		logic watchEnable;
		logic watchBypass;
		logic watchOscRun;
		logic lfSelWatch;
		logic frameLock;
		root_sel_e rootSel;
		logic [LOW_DIV_W-1:0] lowDiv;
		logic lowTick;
		logic lfTick;
		logic [MAIN_DIV_W-1:0] mainDiv;
		logic [MAIN_DIV_W-1:0] mainPeriod;
		logic mainTick;
		logic [FRAME_W-1:0] frameCount;
		logic rootTick;
		logic [2:0] xtalSync;
		logic [2:0] extSync;
		logic [2:0] wcOscSync;
		logic [2:0] wcPinSync;
		logic [DATA_W-1:0] rdata;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	ready_timer_if readyLink();

	ready_timer #(
		.STAB_CYCLES(CRYSTAL_STAB_CYCLES_P)
	) crystalTimer (
		.clk(clk),
		.rst(rst),
		.port(readyLink.timer)
	);

	assign readyLink.enable = s_r.crystalEnable;

	always_comb
	begin
		logic xtalEdge;
		logic extEdge;
		logic watchEdge;
		logic watchTick;
		logic mainAvail;
		xtalEdge = 1'b0;
		extEdge = 1'b0;
		watchEdge = 1'b0;
		watchTick = 1'b0;
		mainAvail = 1'b0;
		s_nxt = s_r;
		s_nxt.rdata = '0;

		// pin clocks pass two flops; the third only feeds the edge detect
		s_nxt.xtalSync = {s_r.xtalSync[1:0], crystalOscClk};
		s_nxt.extSync = {s_r.extSync[1:0], externalClockPin};
		s_nxt.wcOscSync = {s_r.wcOscSync[1:0], watchCrystalOscClk};
		s_nxt.wcPinSync = {s_r.wcPinSync[1:0], watchCrystalPinClk};
		xtalEdge = s_r.xtalSync[1] & ~s_r.xtalSync[2];
		// sampled at 250 MHz, a 100 MHz pin clock is near the limit of what edge detection can follow
		extEdge = s_r.extSync[1] & ~s_r.extSync[2];
		if (s_r.watchBypass)
			watchEdge = s_r.wcPinSync[1] & ~s_r.wcPinSync[2];
		else
			watchEdge = s_r.wcOscSync[1] & ~s_r.wcOscSync[2];
		watchTick = watchEdge & (s_r.watchEnable | s_r.watchBypass);

		if (regWrite)
		begin
			unique case (regAddr)
				CRYSTAL_OSC_CONFIG_OFS:
				begin
					s_nxt.crystalEnable = regWdata[CRYSTAL_ENABLE_BIT];
					s_nxt.autoGain = regWdata[AUTO_GAIN_BIT];
				end
				CRYSTAL_OSC_TRIM_OFS:
				begin
					s_nxt.ampTrim = regWdata[AMP_TRIM_LSB +: AMP_TRIM_W];
					s_nxt.detTrim = regWdata[DET_TRIM_LSB +: DET_TRIM_W];
					s_nxt.gainTrim = regWdata[GAIN_TRIM_LSB +: GAIN_TRIM_W];
					s_nxt.resTrim = regWdata[RES_TRIM_LSB +: RES_TRIM_W];
					s_nxt.filtTrim = regWdata[FILT_TRIM_LSB +: FILT_TRIM_W];
				end
				LOW_SPEED_OSC_CONFIG_OFS:
				begin
					// a locked watchdog would lose its only clock
					if (regWdata[LOW_ENABLE_BIT] || !s_r.wdLock)
						s_nxt.lowEnable = regWdata[LOW_ENABLE_BIT];
					s_nxt.keepAlive = regWdata[KEEP_ALIVE_BIT];
				end
				WATCHDOG_CONTROL_OFS:
				begin
					s_nxt.wdEnable = regWdata[WD_ENABLE_BIT];
					s_nxt.wdLock = regWdata[WD_LOCK_BIT];
					if (regWdata[WD_ENABLE_BIT] && !s_r.wdEnable)
						s_nxt.lowEnable = 1'b1;
				end
				BACKUP_DOMAIN_CONTROL_OFS:
				begin
					s_nxt.watchEnable = regWdata[WATCH_ENABLE_BIT];
					s_nxt.watchBypass = regWdata[WATCH_BYPASS_BIT];
					s_nxt.lfSelWatch = regWdata[LF_SEL_WATCH_BIT];
				end
				MAIN_OSC_CONTROL_OFS:
				begin
					s_nxt.frameLock = regWdata[FRAME_LOCK_BIT];
					s_nxt.rootSel = root_sel_e'(regWdata[ROOT_SEL_LSB +: 2]);
				end
				default:
				begin
				end
			endcase
		end

		// power events stop the oscillator unless kept alive; they win over a same-cycle write
		if (powerEvent)
			s_nxt.lowEnable = s_r.lowEnable & s_r.keepAlive;

		// drive level follows the amplitude trim only under auto gain control
		s_nxt.driveLevel = s_nxt.autoGain ? s_nxt.ampTrim : '0;
		// bypass powers the watch oscillator down, the pin clock takes its place
		s_nxt.watchOscRun = s_nxt.watchEnable & ~s_nxt.watchBypass;

		// low-speed oscillator: free-running, not gated by power mode
		s_nxt.lowTick = 1'b0;
		if (s_r.lowEnable)
		begin
			if (s_r.lowDiv == LOW_DIV_LAST)
			begin
				s_nxt.lowDiv = '0;
				s_nxt.lowTick = 1'b1;
			end
			else
				s_nxt.lowDiv = s_r.lowDiv + LOW_DIV_ONE;
		end
		else
			s_nxt.lowDiv = '0;

		s_nxt.lfTick = s_r.lfSelWatch ? watchTick : s_r.lowTick;

		// main oscillator
		mainAvail = (powerMode == PWR_LP) || (powerMode == PWR_ULP);
		s_nxt.mainTick = 1'b0;
		if (mainAvail)
		begin
			if (s_r.mainDiv >= s_r.mainPeriod - MAIN_ONE)
			begin
				s_nxt.mainDiv = '0;
				s_nxt.mainTick = 1'b1;
			end
			else
				s_nxt.mainDiv = s_r.mainDiv + MAIN_ONE;
		end
		else
			s_nxt.mainDiv = '0;

		// frame trim: the frame marker is the reference, ticks per frame should be nominal
		if (s_r.frameLock && usbSof)
		begin
			if (s_r.frameCount < MAIN_TICKS_PER_FRAME && s_r.mainPeriod > MAIN_DIV_MIN)
				s_nxt.mainPeriod = s_r.mainPeriod - MAIN_ONE;
			else if (s_r.frameCount > MAIN_TICKS_PER_FRAME && s_r.mainPeriod < MAIN_DIV_MAX)
				s_nxt.mainPeriod = s_r.mainPeriod + MAIN_ONE;
			s_nxt.frameCount = '0;
		end
		else if (!s_r.frameLock)
			s_nxt.frameCount = '0;
		else if (s_r.mainTick && s_r.frameCount != FRAME_SAT)
			s_nxt.frameCount = s_r.frameCount + FRAME_ONE;

		// clock path source; an illegal select code gives no ticks
		unique case (s_r.rootSel)
			ROOT_MAIN:
				s_nxt.rootTick = s_r.mainTick;
			ROOT_EXTERNAL:
				s_nxt.rootTick = extEdge;
			ROOT_CRYSTAL:
				s_nxt.rootTick = xtalEdge & readyLink.ready;
			default:
				s_nxt.rootTick = 1'b0;
		endcase

		if (regRead)
		begin
			unique case (regAddr)
				CRYSTAL_OSC_CONFIG_OFS:
				begin
					s_nxt.rdata[CRYSTAL_ENABLE_BIT] = s_r.crystalEnable;
					s_nxt.rdata[AUTO_GAIN_BIT] = s_r.autoGain;
				end
				CRYSTAL_OSC_TRIM_OFS:
				begin
					s_nxt.rdata[AMP_TRIM_LSB +: AMP_TRIM_W] = s_r.ampTrim;
					s_nxt.rdata[DET_TRIM_LSB +: DET_TRIM_W] = s_r.detTrim;
					s_nxt.rdata[GAIN_TRIM_LSB +: GAIN_TRIM_W] = s_r.gainTrim;
					s_nxt.rdata[RES_TRIM_LSB +: RES_TRIM_W] = s_r.resTrim;
					s_nxt.rdata[FILT_TRIM_LSB +: FILT_TRIM_W] = s_r.filtTrim;
				end
				CRYSTAL_OSC_STATUS_OFS:
					s_nxt.rdata[CRYSTAL_READY_BIT] = readyLink.ready;
				LOW_SPEED_OSC_CONFIG_OFS:
				begin
					s_nxt.rdata[LOW_ENABLE_BIT] = s_r.lowEnable;
					s_nxt.rdata[KEEP_ALIVE_BIT] = s_r.keepAlive;
				end
				WATCHDOG_CONTROL_OFS:
				begin
					s_nxt.rdata[WD_ENABLE_BIT] = s_r.wdEnable;
					s_nxt.rdata[WD_LOCK_BIT] = s_r.wdLock;
				end
				BACKUP_DOMAIN_CONTROL_OFS:
				begin
					s_nxt.rdata[WATCH_ENABLE_BIT] = s_r.watchEnable;
					s_nxt.rdata[WATCH_BYPASS_BIT] = s_r.watchBypass;
					s_nxt.rdata[LF_SEL_WATCH_BIT] = s_r.lfSelWatch;
				end
				MAIN_OSC_CONTROL_OFS:
				begin
					s_nxt.rdata[FRAME_LOCK_BIT] = s_r.frameLock;
					s_nxt.rdata[ROOT_SEL_LSB +: 2] = s_r.rootSel;
					s_nxt.rdata[MAIN_PERIOD_LSB +: MAIN_DIV_W] = s_r.mainPeriod;
				end
				default:
					s_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.lowEnable <= LOW_ENABLE_RST;
			s_r.wdLock <= WD_LOCK_RST;
			s_r.mainPeriod <= MAIN_DIV_NOM;
			s_r.rootSel <= ROOT_MAIN;
		end
		else
			s_r <= s_nxt;
	end

	assign regRdata = s_r.rdata;
	assign crystalOscEnable = s_r.crystalEnable;
	assign crystalAutoGain = s_r.autoGain;
	assign crystalDriveLevel = s_r.driveLevel;
	assign amplitudeDetectTrim = s_r.detTrim;
	assign gainTrim = s_r.gainTrim;
	assign filterResistorTrim = s_r.resTrim;
	assign filterTrim = s_r.filtTrim;
	assign crystalOscReady = readyLink.ready;
	assign lowSpeedOscRun = s_r.lowEnable;
	assign watchCrystalOscRun = s_r.watchOscRun;
	// no selector exists for the watchdog source on purpose
	assign watchdogTick = s_r.lowTick;
	assign backupDomainTick = s_r.lfTick;
	assign multiWatchdogTick = s_r.lfTick;
	assign mainOscTick = s_r.mainTick;
	assign clockPathTick = s_r.rootTick;
endmodule : clock_source_control

// ### dv/crystal_partner.sv
// crystals and the external clock pin on the far side of the block
`timescale 1ns/1ns
module crystal_partner
#(
	parameter int CRYSTAL_HALF_NS = 10,
	parameter int EXT_HALF_NS = 6,
	parameter int WATCH_HALF_NS = 20,
	parameter int WATCH_PIN_HALF_NS = 28
)
(
	input wire logic crystalEnable,
	input wire logic watchEnable,
	output logic crystalOscClk,
	output logic externalClockPin,
	output logic watchCrystalOscClk,
	output logic watchCrystalPinClk
);
	initial
	begin
		crystalOscClk = 1'b0;
		externalClockPin = 1'b0;
		watchCrystalOscClk = 1'b0;
		watchCrystalPinClk = 1'b0;
	end
	// a stopped crystal gives no edges, so it sits low
	always #CRYSTAL_HALF_NS crystalOscClk = crystalEnable ? ~crystalOscClk : 1'b0;
	// 12 ns period, inside the 100 MHz ceiling
	always #EXT_HALF_NS externalClockPin = ~externalClockPin;
	always #WATCH_HALF_NS watchCrystalOscClk = watchEnable ? ~watchCrystalOscClk : 1'b0;
	always #WATCH_PIN_HALF_NS watchCrystalPinClk = ~watchCrystalPinClk;
endmodule : crystal_partner

// ### dv/clock_source_chk.sv
// port assertions for the clock source control block
`timescale 1ns/1ns
module clock_source_chk
	import clock_source_pkg::*;
#(
	parameter int CRYSTAL_STAB_CYCLES_P = CRYSTAL_STAB_CYCLES,
	parameter int LOW_SPEED_DIV_P = LOW_SPEED_DIV
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire power_mode_e powerMode,
	input wire logic powerEvent,
	input wire logic crystalOscEnable,
	input wire logic crystalAutoGain,
	input wire logic [AMP_TRIM_W-1:0] crystalDriveLevel,
	input wire logic crystalOscReady,
	input wire logic lowSpeedOscRun,
	input wire logic watchCrystalOscRun,
	input wire logic watchdogTick,
	input wire logic backupDomainTick,
	input wire logic multiWatchdogTick,
	input wire logic mainOscTick
);
	logic wdEnR;
	logic lockR;
	logic keepR;
	logic lfSelR;
	int waitCnt;
	wire logic lowWr = regWrite && regAddr == LOW_SPEED_OSC_CONFIG_OFS;
	wire logic wdWr = regWrite && regAddr == WATCHDOG_CONTROL_OFS;
	wire logic bkWr = regWrite && regAddr == BACKUP_DOMAIN_CONTROL_OFS;

	// mirrors of the control bits, cleared as the block clears them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdEnR <= 1'b0;
			lockR <= WD_LOCK_RST;
			keepR <= 1'b0;
			lfSelR <= 1'b0;
			waitCnt <= 0;
		end
		else
		begin
			wdEnR <= wdWr ? regWdata[WD_ENABLE_BIT] : wdEnR;
			lockR <= wdWr ? regWdata[WD_LOCK_BIT] : lockR;
			keepR <= lowWr ? regWdata[KEEP_ALIVE_BIT] : keepR;
			lfSelR <= bkWr ? regWdata[LF_SEL_WATCH_BIT] : lfSelR;
			waitCnt <= crystalOscEnable ? waitCnt + 1 : 0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	lock_hold_a: assert property (
		lowWr && !regWdata[LOW_ENABLE_BIT] && lockR && lowSpeedOscRun && !powerEvent |=> lowSpeedOscRun)
		else $error("low-speed osc stopped while locked");
	wd_force_a: assert property (
		wdWr && regWdata[WD_ENABLE_BIT] && !wdEnR && !powerEvent |=> lowSpeedOscRun)
		else $error("watchdog enable did not start low-speed osc");
	wd_source_a: assert property (watchdogTick |-> $past(lowSpeedOscRun))
		else $error("watchdog tick without low-speed osc");
	low_enable_a: assert property (
		lowWr && !lockR && !powerEvent |=> lowSpeedOscRun == $past(regWdata[LOW_ENABLE_BIT]))
		else $error("low-speed enable not taken");
	keep_alive_a: assert property (
		powerEvent && !regWrite |=> lowSpeedOscRun == $past(lowSpeedOscRun && keepR))
		else $error("power event result wrong");
	lf_route_a: assert property (watchdogTick && !lfSelR |=> backupDomainTick && multiWatchdogTick)
		else $error("low-speed tick not routed to the low-frequency clock");
	lf_equal_a: assert property (backupDomainTick == multiWatchdogTick)
		else $error("backup and multi-counter ticks differ");
	drive_gate_a: assert property (!crystalAutoGain |-> crystalDriveLevel == '0)
		else $error("drive level without auto gain");
	main_mode_a: assert property (
		!(powerMode inside {PWR_LP, PWR_ULP}) [*2] |-> !mainOscTick)
		else $error("main osc tick outside low-power modes");
	watch_run_a: assert property (
		bkWr |=> watchCrystalOscRun == ($past(regWdata[WATCH_ENABLE_BIT]) && !$past(regWdata[WATCH_BYPASS_BIT])))
		else $error("watch crystal run wrong");
	ready_rise_a: assert property ($rose(crystalOscReady) |-> waitCnt == CRYSTAL_STAB_CYCLES_P)
		else $error("crystal ready early or late");
	ready_drop_a: assert property (!crystalOscEnable [*2] |-> !crystalOscReady)
		else $error("crystal ready without enable");
endmodule : clock_source_chk

bind clock_source_control clock_source_chk #(.CRYSTAL_STAB_CYCLES_P(CRYSTAL_STAB_CYCLES_P),
	.LOW_SPEED_DIV_P(LOW_SPEED_DIV_P)) chk (.clk, .rst, .regAddr, .regWdata, .regWrite, .powerMode,
	.powerEvent, .crystalOscEnable, .crystalAutoGain, .crystalDriveLevel, .crystalOscReady,
	.lowSpeedOscRun, .watchCrystalOscRun, .watchdogTick, .backupDomainTick, .multiWatchdogTick, .mainOscTick);

// ### dv/test_clock_source_control.sv
// self-checking bench for the clock source control block
`timescale 1ns/1ns
module test_clock_source_control
	import clock_source_pkg::*;
;
	localparam int STAB = 20;
	localparam int DIV = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [DATA_W-1:0] regRdata;
	power_mode_e powerMode = PWR_LP;
	logic powerEvent = 1'b0;
	logic usbSof = 1'b0;
	logic crystalOscClk, externalClockPin, watchCrystalOscClk, watchCrystalPinClk;
	logic crystalOscEnable, crystalAutoGain, crystalOscReady, lowSpeedOscRun, watchCrystalOscRun;
	logic watchdogTick, backupDomainTick, multiWatchdogTick, mainOscTick, clockPathTick;
	logic [AMP_TRIM_W-1:0] crystalDriveLevel;
	logic [DET_TRIM_W-1:0] amplitudeDetectTrim;
	logic [GAIN_TRIM_W-1:0] gainTrim;
	logic [RES_TRIM_W-1:0] filterResistorTrim;
	logic [FILT_TRIM_W-1:0] filterTrim;
	int nErrors = 0;
	int nTests = 0;
	int cycles = 0;
	int nWd, nBk, nMain, nPath, n;

	always #2 clk = ~clk;

	clock_source_control #(.CRYSTAL_STAB_CYCLES_P(STAB), .LOW_SPEED_DIV_P(DIV)) DUT (.clk, .rst, .regAddr,
		.regWdata, .regWrite, .regRead, .regRdata, .powerMode, .powerEvent, .usbSof, .crystalOscClk,
		.externalClockPin, .watchCrystalOscClk, .watchCrystalPinClk, .crystalOscEnable, .crystalAutoGain,
		.crystalDriveLevel, .amplitudeDetectTrim, .gainTrim, .filterResistorTrim, .filterTrim,
		.crystalOscReady, .lowSpeedOscRun, .watchCrystalOscRun, .watchdogTick, .backupDomainTick,
		.multiWatchdogTick, .mainOscTick, .clockPathTick);

	crystal_partner partner (.crystalEnable(crystalOscEnable), .watchEnable(watchCrystalOscRun), .crystalOscClk,
		.externalClockPin, .watchCrystalOscClk, .watchCrystalPinClk);

	task automatic end_of_test();
		$display("checks %0d errors %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// the ceiling is several times the expected run length
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		nWd <= nWd + int'(watchdogTick === 1'b1);
		nBk <= nBk + int'(backupDomainTick === 1'b1);
		nMain <= nMain + int'(mainOscTick === 1'b1);
		nPath <= nPath + int'(clockPathTick === 1'b1);
		if (cycles == 5000)
		begin
			nErrors++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp)
		begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkIn(input string what, input int lo, input int hi, input int got);
		nTests++;
		if (got < lo || got > hi)
		begin
			nErrors++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chkIn

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk(what, exp, regRdata);
	endtask : rd

	task automatic count(input int cyc);
		nWd = 0;
		nBk = 0;
		nMain = 0;
		nPath = 0;
		repeat (cyc) @(posedge clk);
		#1;
	endtask : count

	task automatic pulseEvent(input logic sof);
		@(posedge clk);
		if (sof)
			usbSof <= 1'b1;
		else
			powerEvent <= 1'b1;
		@(posedge clk);
		usbSof <= 1'b0;
		powerEvent <= 1'b0;
		#1;
	endtask : pulseEvent

	task automatic testReset();
		chk("lowRun", 1, lowSpeedOscRun);
		rd(LOW_SPEED_OSC_CONFIG_OFS, 32'h0000_0001, "lowCfg");
		rd(CRYSTAL_OSC_STATUS_OFS, 32'h0000_0000, "status");
		rd(MAIN_OSC_CONTROL_OFS, 32'h0000_1F00, "mainCtl");
		rd(8'h40, 32'h0000_0000, "unmapped");
		@(posedge clk);
		#1;
		chk("rdataIdle", 0, regRdata);
	endtask : testReset

	task automatic testCrystal();
		wr(CRYSTAL_OSC_TRIM_OFS, 32'h0007_316E);
		chk("detTrim", 6, amplitudeDetectTrim);
		chk("gainTrim", 1, gainTrim);
		chk("resTrim", 3, filterResistorTrim);
		chk("filtTrim", 7, filterTrim);
		chk("driveOff", 0, crystalDriveLevel);
		wr(MAIN_OSC_CONTROL_OFS, 32'h0000_0020);
		wr(CRYSTAL_OSC_CONFIG_OFS, 32'h0000_0003);
		chk("driveOn", 32'hE, crystalDriveLevel);
		chk("xtalEnable", 1, crystalOscEnable);
		chk("autoGain", 1, crystalAutoGain);
		nPath = 0;
		n = 0;
		while (crystalOscReady !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("readyWait", STAB, n);
		chkIn("earlyTicks", 0, 0, nPath);
		rd(CRYSTAL_OSC_STATUS_OFS, 32'h0000_0001, "status");
		count(100);
		chkIn("xtalTicks", 19, 21, nPath);
		wr(CRYSTAL_OSC_CONFIG_OFS, 32'h0000_0000);
		@(posedge clk);
		#1;
		chk("readyOff", 0, crystalOscReady);
		chk("driveOff", 0, crystalDriveLevel);
		count(4);
		count(20);
		chkIn("xtalOff", 0, 0, nPath);
	endtask : testCrystal

	task automatic testLowSpeed();
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0000);
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0003);
		wr(LOW_SPEED_OSC_CONFIG_OFS, 32'h0000_0000);
		chk("lockedRun", 1, lowSpeedOscRun);
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0001);
		wr(LOW_SPEED_OSC_CONFIG_OFS, 32'h0000_0000);
		chk("stopRun", 0, lowSpeedOscRun);
		// a tick launched at the stopping edge may still stand for one cycle
		count(1);
		count(40);
		chkIn("wdTicks", 0, 0, nWd);
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0000);
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0001);
		chk("forcedRun", 1, lowSpeedOscRun);
		wr(WATCHDOG_CONTROL_OFS, 32'h0000_0000);
		pulseEvent(1'b0);
		chk("eventStop", 0, lowSpeedOscRun);
		wr(LOW_SPEED_OSC_CONFIG_OFS, 32'h0000_0003);
		pulseEvent(1'b0);
		chk("eventKeep", 1, lowSpeedOscRun);
	endtask : testLowSpeed

	task automatic testTicks();
		count(80);
		chkIn("wdTicks", 10, 10, nWd);
		chkIn("bkTicks", 10, 10, nBk);
		wr(BACKUP_DOMAIN_CONTROL_OFS, 32'h0000_0006);
		chk("watchRun", 0, watchCrystalOscRun);
		count(140);
		chkIn("bypassTicks", 9, 11, nBk);
		wr(BACKUP_DOMAIN_CONTROL_OFS, 32'h0000_0004);
		count(10);
		count(60);
		chkIn("stoppedTicks", 0, 0, nBk);
		wr(BACKUP_DOMAIN_CONTROL_OFS, 32'h0000_0005);
		chk("watchRun", 1, watchCrystalOscRun);
		count(140);
		chkIn("watchTicks", 13, 15, nBk);
		wr(BACKUP_DOMAIN_CONTROL_OFS, 32'h0000_0000);
		wr(MAIN_OSC_CONTROL_OFS, 32'h0000_0010);
		count(120);
		chkIn("extTicks", 39, 41, nPath);
		wr(MAIN_OSC_CONTROL_OFS, 32'h0000_0000);
		count(124);
		chkIn("mainTicks", 3, 5, nMain);
		@(posedge clk);
		powerMode <= PWR_DEEPSLEEP;
		count(5);
		count(62);
		chkIn("sleepTicks", 0, 0, nMain);
		@(posedge clk);
		powerMode <= PWR_LP;
		pulseEvent(1'b1);
		rd(MAIN_OSC_CONTROL_OFS, 32'h0000_1F00, "noTrim");
		wr(MAIN_OSC_CONTROL_OFS, 32'h0000_0001);
		pulseEvent(1'b1);
		count(10);
		pulseEvent(1'b1);
		rd(MAIN_OSC_CONTROL_OFS, 32'h0000_1D01, "trimmed");
	endtask : testTicks

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		testReset();
		testCrystal();
		testLowSpeed();
		testTicks();
		end_of_test();
	end
endmodule : test_clock_source_control
